// File: design/aux_pin_defines.svh
// Purpose: constants for the auxiliary pin function select block
// Assumes: 100 MHz core clock
// Notes: function codes are the values held in configuration memory
`ifndef AUX_PIN_DEFINES_SVH
`define AUX_PIN_DEFINES_SVH

`define FUNC_W 5
`define FUNC_TRISTATE 5'h00
`define FUNC_DRIVE_1 5'h01
`define FUNC_DRIVE_0 5'h02
`define FUNC_POWER_EN 5'h03
`define FUNC_TX_LED 5'h04
`define FUNC_RX_LED 5'h05
`define FUNC_ANY_LED 5'h06
`define FUNC_SLEEP 5'h07
`define FUNC_CLK_FAST 5'h08
`define FUNC_CLK_MID 5'h09
`define FUNC_CLK_SLOW 5'h0a
`define FUNC_CHARGER 5'h0b
`define FUNC_CHARGER_N 5'h0c
`define FUNC_BB_WR 5'h0d
`define FUNC_BB_RD 5'h0e
`define FUNC_BUS_SENSE 5'h0f
`define FUNC_TIMESTAMP 5'h10
`define FUNC_KEEP_AWAKE 5'h11

// factory defaults
`define DEFAULT_PIN_A 5'h0f
`define DEFAULT_PIN_B 5'h11

// led pulse length
`define LED_PULSE_NS 50000
`define CLK_PERIOD_NS 10
`define LED_PULSE_CYCLES (`LED_PULSE_NS / `CLK_PERIOD_NS)

// clock output half periods in core cycles, rounded to the nearest
// count the 100 MHz clock allows
`define CLK_DIV_W 3
`define CLK_HALF_FAST 3'h2
`define CLK_HALF_MID 3'h4

`endif

// File: design/aux_pin_pkg.sv
// Purpose: types for the auxiliary pin function select block
// Assumes: aux_pin_defines.svh supplies widths
// Notes: none
`include "aux_pin_defines.svh"

package aux_pin_pkg;

	typedef logic [`FUNC_W-1:0] func_code_t;

	// usb core status passed in as one bundle
	typedef struct packed
	{
		logic configured;
		logic suspended;
		logic tx_active;
		logic rx_active;
		logic sof_seen;
		logic on_charger;
		logic charger_cancels_sleep;
		logic bb_write_strobe_n;
		logic bb_read_strobe_n;
	} usb_status_t;

	// one pin's output value and enable
	typedef struct packed
	{
		logic out;
		logic oe_n;
	} pin_drive_t;

endpackage

// File: design/aux_clock_gen.sv
// Purpose: divided clock outputs for the auxiliary pins
// Assumes: 100 MHz core clock, so outputs approximate the named rates
// Notes: a true 24/12/6 MHz needs a 48 MHz source; counts are parameters
`timescale 1ns/100ps
`default_nettype none
`include "aux_pin_defines.svh"

module aux_clock_gen
#(
	parameter logic [`CLK_DIV_W-1:0] HALF_FAST = `CLK_HALF_FAST,
	parameter logic [`CLK_DIV_W-1:0] HALF_MID = `CLK_HALF_MID
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic stop,
	output logic clk_out_fast,
	output logic clk_out_mid,
	output logic clk_out_slow
);
	import aux_pin_pkg::*;

	typedef struct packed
	{
		logic [`CLK_DIV_W-1:0] cnt_fast;
		logic [`CLK_DIV_W-1:0] cnt_mid;
		logic fast;
		logic mid;
		logic slow;
	} state_t;

	state_t st;
	state_t next_st;

	always_comb
	begin
		next_st = st;
		if (stop)
		begin
			next_st = '0;
		end
		else
		begin
			next_st.cnt_fast = st.cnt_fast + 3'h1;
			if (st.cnt_fast == HALF_FAST - 3'h1)
			begin
				next_st.cnt_fast = '0;
				next_st.fast = ~st.fast;
			end
			next_st.cnt_mid = st.cnt_mid + 3'h1;
			if (st.cnt_mid == HALF_MID - 3'h1)
			begin
				next_st.cnt_mid = '0;
				next_st.mid = ~st.mid;
				// slow is mid halved
				if (st.mid)
				begin
					next_st.slow = ~st.slow;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

	assign clk_out_fast = st.fast;
	assign clk_out_mid = st.mid;
	assign clk_out_slow = st.slow;

endmodule
`default_nettype wire

// File: design/aux_led_stretch.sv
// Purpose: stretch short activity into a visible low pulse
// Assumes: activity is a same-clock level or pulse
// Notes: retriggers while activity continues
`timescale 1ns/100ps
`default_nettype none
`include "aux_pin_defines.svh"

module aux_led_stretch
#(
	parameter int PULSE_CYCLES = `LED_PULSE_CYCLES
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic activity,
	output logic led_n
);
	import aux_pin_pkg::*;

	localparam int CW = $clog2(PULSE_CYCLES + 1);

	typedef struct packed
	{
		logic [CW-1:0] cnt;
		logic led_n;
	} state_t;

	state_t st;
	state_t next_st;

	always_comb
	begin
		next_st = st;
		if (activity)
		begin
			next_st.cnt = CW'(PULSE_CYCLES);
		end
		else if (st.cnt != '0)
		begin
			next_st.cnt = st.cnt - CW'(1);
		end
		next_st.led_n = !(activity || st.cnt > CW'(1));
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st <= '{cnt: '0, led_n: 1'b1};
		end
		else
		begin
			st <= next_st;
		end
	end

	assign led_n = st.led_n;

endmodule
`default_nettype wire

// File: design/aux_pin_mux.sv
// Purpose: function select for two configurable auxiliary pins
// Assumes: usb status is on the core clock; pin inputs are asynchronous
// Notes: open-drain functions only ever drive low; oe low means driving
// How it works
// - each pin can float, drive constant one, or drive constant zero
// - power enable low once configured, released high during suspend
// - power enable is open drain: drives low only, floats for high
// - transmit led pulses low open drain while sending to host
// - receive led pulses low open drain while receiving from host
// - combined led pulses low on either transmit or receive
// - sleep indicator low during suspend, high otherwise
// - with charger option set, sleep indicator held high on charger port
// - clock functions output fast, mid or slow continuous clock
// - clock outputs stop during suspend and resume afterwards
// - charger detect high drives high on dedicated charger, low otherwise
// - charger detect low pulls low open drain, no internal pull-up
// - bit-bang write strobe output, active low
// - bit-bang read strobe output, active low
// - timestamp output toggles once per start of frame
// - keep-awake input low holds off suspend
// - every function selectable independently on both pins
// - factory default for pin b is keep-awake input
// - factory default for pin a is bus power sense input
`timescale 1ns/100ps
`default_nettype none
`include "aux_pin_defines.svh"

module aux_pin_mux
#(
	parameter int LED_PULSE_CYCLES = `LED_PULSE_CYCLES
)
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// configuration memory
	input wire logic CFG_VALID_I,
	input wire logic CFG_PROGRAMMED_I,
	input wire aux_pin_pkg::func_code_t CFG_FUNC_A_I,
	input wire aux_pin_pkg::func_code_t CFG_FUNC_B_I,
	// usb core status
	input wire aux_pin_pkg::usb_status_t USB_STATUS_I,
	// usb core feedback
	output logic KEEP_AWAKE_O,
	output logic BUS_POWER_SENSE_O,
	output logic BUS_POWER_SENSE_VALID_O,
	output logic CFG_LOADED_O,
	// auxiliary pin a
	input wire logic AUX_PIN_A_I,
	output logic AUX_PIN_A_O,
	output logic AUX_PIN_A_OE_N_O,
	// auxiliary pin b
	input wire logic AUX_PIN_B_I,
	output logic AUX_PIN_B_O,
	output logic AUX_PIN_B_OE_N_O
);
	import aux_pin_pkg::*;

	////////////////////////////////////////////////////////////////////

	typedef enum logic [1:0]
	{
		LOAD_WAIT = 2'b01,
		LOAD_DONE = 2'b10
	} load_state_t;

	typedef struct packed
	{
		load_state_t load;
		func_code_t func_a;
		func_code_t func_b;
		logic [1:0] sync_a;
		logic [1:0] sync_b;
		logic timestamp;
		pin_drive_t drive_a;
		pin_drive_t drive_b;
		logic keep_awake;
		logic bus_sense;
		logic bus_sense_valid;
	} state_t;

	state_t st;
	state_t next_st;

	logic clk_fast;
	logic clk_mid;
	logic clk_slow;
	logic tx_led_n;
	logic rx_led_n;
	logic any_led_n;

	////////////////////////////////////////////////////////////////////

	// open drain helper: low drives zero, high floats
	function automatic pin_drive_t open_drain(input logic level);
		pin_drive_t d;
		d.out = 1'b0;
		d.oe_n = level;
		return d;
	endfunction

	function automatic pin_drive_t push_pull(input logic level);
		pin_drive_t d;
		d.out = level;
		d.oe_n = 1'b0;
		return d;
	endfunction

	// released pin: enable high, output parked low
	function automatic pin_drive_t float_pin();
		pin_drive_t d;
		d.out = 1'b0;
		d.oe_n = 1'b1;
		return d;
	endfunction

	// one decoder serves both pins
	function automatic pin_drive_t select_drive(
		input func_code_t f,
		input usb_status_t u,
		input logic ts,
		input logic cf,
		input logic cm,
		input logic cs,
		input logic tl,
		input logic rl,
		input logic al
	);
		pin_drive_t d;
		d = float_pin();
		case (f)
			`FUNC_DRIVE_1: d = push_pull(1'b1);
			`FUNC_DRIVE_0: d = push_pull(1'b0);
			`FUNC_POWER_EN: d = open_drain(!u.configured || u.suspended);
			`FUNC_TX_LED: d = open_drain(tl);
			`FUNC_RX_LED: d = open_drain(rl);
			`FUNC_ANY_LED: d = open_drain(al);
			`FUNC_SLEEP:
				// charger option overrides suspend
				d = push_pull(!u.suspended || (u.charger_cancels_sleep && u.on_charger));
			`FUNC_CLK_FAST: d = push_pull(cf);
			`FUNC_CLK_MID: d = push_pull(cm);
			`FUNC_CLK_SLOW: d = push_pull(cs);
			`FUNC_CHARGER: d = push_pull(u.on_charger);
			`FUNC_CHARGER_N: d = open_drain(!u.on_charger);
			`FUNC_BB_WR: d = push_pull(u.bb_write_strobe_n);
			`FUNC_BB_RD: d = push_pull(u.bb_read_strobe_n);
			`FUNC_TIMESTAMP: d = push_pull(ts);
			// tristate, sense inputs and unknown codes float
			default: d = float_pin();
		endcase
		return d;
	endfunction

	////////////////////////////////////////////////////////////////////

	aux_clock_gen u_clock_gen
	(
		.clk(CLK_I),
		.resetn(RESETN_I),
		.stop(USB_STATUS_I.suspended),
		.clk_out_fast(clk_fast),
		.clk_out_mid(clk_mid),
		.clk_out_slow(clk_slow)
	);

	aux_led_stretch #(.PULSE_CYCLES(LED_PULSE_CYCLES)) u_tx_led
	(
		.clk(CLK_I),
		.resetn(RESETN_I),
		.activity(USB_STATUS_I.tx_active),
		.led_n(tx_led_n)
	);

	aux_led_stretch #(.PULSE_CYCLES(LED_PULSE_CYCLES)) u_rx_led
	(
		.clk(CLK_I),
		.resetn(RESETN_I),
		.activity(USB_STATUS_I.rx_active),
		.led_n(rx_led_n)
	);

	aux_led_stretch #(.PULSE_CYCLES(LED_PULSE_CYCLES)) u_any_led
	(
		.clk(CLK_I),
		.resetn(RESETN_I),
		.activity(USB_STATUS_I.tx_active || USB_STATUS_I.rx_active),
		.led_n(any_led_n)
	);

	////////////////////////////////////////////////////////////////////

	always_comb
	begin
		next_st = st;
		// pin inputs pass two flops before use; only the second stage is read
		// below, so a metastable first stage never reaches the decode
		next_st.sync_a = {st.sync_a[0], AUX_PIN_A_I};
		next_st.sync_b = {st.sync_b[0], AUX_PIN_B_I};
		unique case (st.load)
			LOAD_WAIT:
			begin
				if (CFG_VALID_I)
				begin
					if (CFG_PROGRAMMED_I)
					begin
						next_st.func_a = CFG_FUNC_A_I;
						next_st.func_b = CFG_FUNC_B_I;
					end
					else
					begin
						next_st.func_a = `DEFAULT_PIN_A;
						next_st.func_b = `DEFAULT_PIN_B;
					end
					next_st.load = LOAD_DONE;
				end
			end
			LOAD_DONE:
			begin
				if (USB_STATUS_I.sof_seen)
				begin
					next_st.timestamp = ~st.timestamp;
				end
			end
		endcase
		if (st.load == LOAD_DONE)
		begin
			next_st.drive_a = select_drive(st.func_a, USB_STATUS_I, st.timestamp,
				clk_fast, clk_mid, clk_slow, tx_led_n, rx_led_n, any_led_n);
			next_st.drive_b = select_drive(st.func_b, USB_STATUS_I, st.timestamp,
				clk_fast, clk_mid, clk_slow, tx_led_n, rx_led_n, any_led_n);
		end
		else
		begin
			// float until the selection is known, so no pin fights the board
			next_st.drive_a = float_pin();
			next_st.drive_b = float_pin();
		end
		next_st.keep_awake = 1'b0;
		next_st.bus_sense_valid = 1'b0;
		next_st.bus_sense = 1'b0;
		if (st.load == LOAD_DONE)
		begin
			// either pin may carry keep-awake; low on the pin holds off suspend
			if (st.func_a == `FUNC_KEEP_AWAKE && !st.sync_a[1])
			begin
				next_st.keep_awake = 1'b1;
			end
			if (st.func_b == `FUNC_KEEP_AWAKE && !st.sync_b[1])
			begin
				next_st.keep_awake = 1'b1;
			end
			// pin a wins if both carry bus sense
			if (st.func_a == `FUNC_BUS_SENSE)
			begin
				next_st.bus_sense_valid = 1'b1;
				next_st.bus_sense = st.sync_a[1];
			end
			else if (st.func_b == `FUNC_BUS_SENSE)
			begin
				next_st.bus_sense_valid = 1'b1;
				next_st.bus_sense = st.sync_b[1];
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			st <= '{
				load: LOAD_WAIT,
				func_a: `FUNC_TRISTATE,
				func_b: `FUNC_TRISTATE,
				sync_a: 2'h0,
				sync_b: 2'h0,
				timestamp: 1'b0,
				drive_a: '{out: 1'b0, oe_n: 1'b1},
				drive_b: '{out: 1'b0, oe_n: 1'b1},
				keep_awake: 1'b0,
				bus_sense: 1'b0,
				bus_sense_valid: 1'b0
			};
		end
		else
		begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////

	assign AUX_PIN_A_O = st.drive_a.out;
	assign AUX_PIN_A_OE_N_O = st.drive_a.oe_n;
	assign AUX_PIN_B_O = st.drive_b.out;
	assign AUX_PIN_B_OE_N_O = st.drive_b.oe_n;
	assign KEEP_AWAKE_O = st.keep_awake;
	assign BUS_POWER_SENSE_O = st.bus_sense;
	assign BUS_POWER_SENSE_VALID_O = st.bus_sense_valid;
	assign CFG_LOADED_O = (st.load == LOAD_DONE);

endmodule
`default_nettype wire

// File: verif/aux_pin_mux_asserts.sv
// Purpose: timing checks on the aux pin function select ports
// Assumes: selection taken at the first CFG_VALID_I edge after reset
// Notes: pin b checks cover the codes that are only tested there, except FUNC_BB_RD
`timescale 1ns/100ps
`default_nettype none
`include "aux_pin_defines.svh"

module aux_pin_mux_asserts
(
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire logic CFG_VALID_I,
	input wire logic CFG_PROGRAMMED_I,
	input wire aux_pin_pkg::func_code_t CFG_FUNC_A_I,
	input wire aux_pin_pkg::func_code_t CFG_FUNC_B_I,
	input wire aux_pin_pkg::usb_status_t USB_STATUS_I,
	input wire logic KEEP_AWAKE_O,
	input wire logic BUS_POWER_SENSE_O,
	input wire logic BUS_POWER_SENSE_VALID_O,
	input wire logic CFG_LOADED_O,
	input wire logic AUX_PIN_A_I,
	input wire logic AUX_PIN_A_O,
	input wire logic AUX_PIN_A_OE_N_O,
	input wire logic AUX_PIN_B_I,
	input wire logic AUX_PIN_B_O,
	input wire logic AUX_PIN_B_OE_N_O
);
	import aux_pin_pkg::*;
	func_code_t fa;
	func_code_t fb;
	usb_status_t ps;
	logic [2:0] lh;
	logic [2:0] sh;
	logic [1:0] sf;
	////////////////////////////////////////////////////////////////////////////////
	// shadow of the loaded selection; history kept so nothing fires near reset
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			fa <= '0;
			fb <= '0;
			ps <= '0;
			lh <= '0;
			sh <= '0;
			sf <= '0;
		end
		else
		begin
			if (CFG_VALID_I && !CFG_LOADED_O)
			begin
				fa <= CFG_PROGRAMMED_I ? CFG_FUNC_A_I : `DEFAULT_PIN_A;
				fb <= CFG_PROGRAMMED_I ? CFG_FUNC_B_I : `DEFAULT_PIN_B;
			end
			ps <= USB_STATUS_I;
			lh <= {lh[1:0], CFG_LOADED_O};
			sh <= {sh[1:0], USB_STATUS_I.suspended};
			sf <= {sf[0], USB_STATUS_I.sof_seen};
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);
	a_float_unloaded: assert property (!CFG_LOADED_O |-> AUX_PIN_A_OE_N_O && AUX_PIN_B_OE_N_O)
		else $error("pin driven before load");
	a_load_holds: assert property (CFG_VALID_I || CFG_LOADED_O |=> CFG_LOADED_O)
		else $error("selection not loaded");
	a_power_open: assert property (lh[0] && fa == `FUNC_POWER_EN |-> !AUX_PIN_A_O
		&& AUX_PIN_A_OE_N_O == !(ps.configured && !ps.suspended))
		else $error("power enable wrong");
	a_sleep_level: assert property (lh[0] && fb == `FUNC_SLEEP |-> !AUX_PIN_B_OE_N_O
		&& AUX_PIN_B_O == (!ps.suspended || (ps.charger_cancels_sleep && ps.on_charger)))
		else $error("sleep pin wrong");
	a_charger_pins: assert property (lh[0] && fb == `FUNC_CHARGER_N |-> !AUX_PIN_B_O
		&& AUX_PIN_B_OE_N_O == !ps.on_charger)
		else $error("charger low pin wrong");
	a_strobe_pass: assert property (lh[0] && fa == `FUNC_BB_WR |-> !AUX_PIN_A_OE_N_O
		&& AUX_PIN_A_O == ps.bb_write_strobe_n)
		else $error("write strobe wrong");
	a_clock_stop: assert property (lh[0] && fa inside {[`FUNC_CLK_FAST:`FUNC_CLK_SLOW]}
		&& &sh |-> !AUX_PIN_A_O)
		else $error("clock runs in suspend");
	a_stamp_toggle: assert property (lh[2] && fa == `FUNC_TIMESTAMP
		|-> (AUX_PIN_A_O != $past(AUX_PIN_A_O)) == sf[1])
		else $error("timestamp toggle wrong");
	a_keep_awake: assert property (lh[2] && fb == `FUNC_KEEP_AWAKE
		|-> KEEP_AWAKE_O == !$past(AUX_PIN_B_I, 3))
		else $error("keep awake wrong");
	a_bus_sense: assert property (lh[2] && fa == `FUNC_BUS_SENSE |-> BUS_POWER_SENSE_VALID_O
		&& BUS_POWER_SENSE_O == $past(AUX_PIN_A_I, 3))
		else $error("bus sense wrong");
endmodule
`default_nettype wire

// File: verif/aux_far_side.sv
// Purpose: board side of one aux pin
// Assumes: board pull-up on every pin
// Notes: outside driver used only while the design floats the pin
`timescale 1ns/100ps
`default_nettype none

module aux_far_side
(
	// design side
	input wire logic out_i,
	input wire logic oe_n_i,
	// outside driver
	input wire logic drive_i,
	input wire logic value_i,
	output logic level_o
);
	// a released open-drain pin reads high through the pull-up unless the outside driver sets its level
	assign level_o = !oe_n_i ? out_i : (drive_i ? value_i : 1'h1);
endmodule
`default_nettype wire

// File: verif/tb_aux_pin_mux.sv
// Purpose: self-checking bench for the aux pin function select
// Assumes: short led pulse of 4 cycles
// Notes: each test reloads the selection through a reset
`timescale 1ns/100ps
`default_nettype none
`include "aux_pin_defines.svh"

module tb_aux_pin_mux;
	import aux_pin_pkg::*;
	logic clk = '0, rst_n = '0, cv = '0, cp = '0, ea = '0, va = '0, eb = '0, vb = '0;
	func_code_t fa = '0, fb = '0;
	usb_status_t st = '0;
	logic ka, bs, bsv, ld, ao, aoe_n, bo, boe_n, la, lb, p;
	int n_fail = 0, num_checks = 0, k, nt;
	logic [3:0] pw [4] = '{4'h0, 4'h8, 4'he, 4'hf};
	logic [7:0] ex [4] = '{8'h7, 8'h1, 8'h6, 8'h7};
	logic [2:0] lvl = 3'h3;

	aux_pin_mux #(.LED_PULSE_CYCLES(4)) i_dut
	(
		.CLK_I(clk), .RESETN_I(rst_n), .CFG_VALID_I(cv), .CFG_PROGRAMMED_I(cp),
		.CFG_FUNC_A_I(fa), .CFG_FUNC_B_I(fb), .USB_STATUS_I(st), .KEEP_AWAKE_O(ka),
		.BUS_POWER_SENSE_O(bs), .BUS_POWER_SENSE_VALID_O(bsv), .CFG_LOADED_O(ld),
		.AUX_PIN_A_I(la), .AUX_PIN_A_O(ao), .AUX_PIN_A_OE_N_O(aoe_n),
		.AUX_PIN_B_I(lb), .AUX_PIN_B_O(bo), .AUX_PIN_B_OE_N_O(boe_n)
	);
	aux_far_side i_side_a (.out_i(ao), .oe_n_i(aoe_n), .drive_i(ea), .value_i(va), .level_o(la));
	aux_far_side i_side_b (.out_i(bo), .oe_n_i(boe_n), .drive_i(eb), .value_i(vb), .level_o(lb));

	initial
		forever #5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		#1;
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
		@(posedge clk);
	endtask
	task print_verdict;
		$display("test done at %0t, checks %0d, mismatches %0d", $time, num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task setup(input func_code_t a, input func_code_t b, input logic pr);
		if (rst_n)
			$display("test done at %0t", $time);
		rst_n <= '0;
		cv <= '0;
		tick(12);
		rst_n <= 1'h1;
		cp <= pr;
		fa <= a;
		fb <= b;
		tick(3);
		chk({aoe_n, boe_n, bsv, ld}, 8'hc);
		cv <= 1'h1;
		k = 0;
		while (ld !== 1'h1 && k < 20)
		begin
			tick(1);
			#1;
			k++;
		end
		tick(1);
		cv <= '0;
		if (k == 20)
		begin
			n_fail++;
			print_verdict;
		end
		tick(2);
	endtask
	// transitions on pin a plus cycles where pin b differs from pin a; window spans whole half periods
	task count(input int n);
		nt = 0;
		#1;
		p = la;
		repeat (n)
		begin
			tick(1);
			#1;
			nt += (la !== p) + (lb !== la);
			p = la;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		setup('0, '0, '0);
		chk({bsv, aoe_n, boe_n}, 8'h7);
		ea <= 1'h1;
		eb <= 1'h1;
		tick(5);
		chk({bs, ka}, 8'h1);
		va <= 1'h1;
		vb <= 1'h1;
		tick(5);
		chk({bs, ka}, 8'h2);
		ea <= '0;
		eb <= '0;
		for (int i = 0; i < 3; i++)
		begin
			setup(func_code_t'(i), func_code_t'(2 - i), 1'h1);
			chk({aoe_n, boe_n, la, lb}, {4'h0, i == 0, i == 2, lvl[i], lvl[2 - i]});
		end
		setup(`FUNC_POWER_EN, `FUNC_SLEEP, 1'h1);
		for (int i = 0; i < 4; i++)
		begin
			{st.configured, st.suspended, st.on_charger, st.charger_cancels_sleep} <= pw[i];
			tick(3);
			chk({aoe_n, la, lb}, ex[i]);
		end
		setup(`FUNC_CHARGER, `FUNC_CHARGER_N, 1'h1);
		for (int i = 0; i < 2; i++)
		begin
			st.on_charger <= i[0];
			tick(3);
			chk({aoe_n, la, boe_n, lb}, i ? 8'h4 : 8'h3);
		end
		setup(`FUNC_BB_WR, `FUNC_BB_RD, 1'h1);
		for (int i = 0; i < 4; i++)
		begin
			{st.bb_write_strobe_n, st.bb_read_strobe_n} <= i[1:0];
			tick(3);
			chk({la, lb}, 8'(i));
		end
		for (int i = 0; i < 3; i++)
		begin
			setup(func_code_t'(`FUNC_CLK_FAST + i), func_code_t'(`FUNC_CLK_FAST + i), 1'h1);
			st.suspended <= '0;
			tick(4);
			count(48);
			chk(8'(nt), 8'(48 >> (i + 1)));
			st.suspended <= 1'h1;
			tick(4);
			count(48);
			chk(8'(nt), 8'h0);
			st.suspended <= '0;
			tick(4);
			count(48);
			chk(8'(nt), 8'(48 >> (i + 1)));
		end
		for (int i = 0; i < 3; i++)
		begin
			setup(func_code_t'(`FUNC_TX_LED + i), `FUNC_TX_LED, 1'h1);
			for (int j = 0; j < 2; j++)
			begin
				{st.tx_active, st.rx_active} <= j ? 2'h1 : 2'h2;
				tick(1);
				{st.tx_active, st.rx_active} <= '0;
				tick(2);
				chk({la, lb}, {6'h0, !(i == 2 || i == j), j == 1});
				tick(8);
				chk({la, lb}, 8'h3);
			end
		end
		setup(`FUNC_TIMESTAMP, `FUNC_KEEP_AWAKE, 1'h1);
		for (int i = 0; i < 3; i++)
		begin
			p = la;
			st.sof_seen <= 1'h1;
			tick(1);
			st.sof_seen <= '0;
			tick(4);
			chk(la, {7'h0, ~p});
		end
		print_verdict;
	end
endmodule

bind aux_pin_mux aux_pin_mux_asserts i_chk
(
	.CLK_I(CLK_I), .RESETN_I(RESETN_I), .CFG_VALID_I(CFG_VALID_I),
	.CFG_PROGRAMMED_I(CFG_PROGRAMMED_I), .CFG_FUNC_A_I(CFG_FUNC_A_I),
	.CFG_FUNC_B_I(CFG_FUNC_B_I), .USB_STATUS_I(USB_STATUS_I), .KEEP_AWAKE_O(KEEP_AWAKE_O),
	.BUS_POWER_SENSE_O(BUS_POWER_SENSE_O), .BUS_POWER_SENSE_VALID_O(BUS_POWER_SENSE_VALID_O),
	.CFG_LOADED_O(CFG_LOADED_O), .AUX_PIN_A_I(AUX_PIN_A_I), .AUX_PIN_A_O(AUX_PIN_A_O),
	.AUX_PIN_A_OE_N_O(AUX_PIN_A_OE_N_O), .AUX_PIN_B_I(AUX_PIN_B_I), .AUX_PIN_B_O(AUX_PIN_B_O),
	.AUX_PIN_B_OE_N_O(AUX_PIN_B_OE_N_O)
);
`default_nettype wire
